// ===== rtl/qdac_i2c_port.v
// Two-wire slave command port of the quad converter
`timescale 1ns/1ps
`include "qdac_defines.vh"
module qdac_i2c_port (
  input wire clk,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire addr_strap_bit0,
  input wire addr_strap_bit1,
  input wire load_strobe_n,
  output reg [63:0] dac_value,
  output reg [7:0] pwrdn_mode
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg scl_s1, scl_s2, scl_d;
  reg sda_s1, sda_s2, sda_d;
  reg ld_s1, ld_s2;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      ld_s1 <= 1'b1;
      ld_s2 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      ld_s1 <= load_strobe_n;
      ld_s2 <= ld_s1;
    end
  end
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  // Start and stop need SCL high on both samples so a data edge is not taken
  wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_WRITE = 2'h2;
  localparam ST_READ = 2'h3;
  reg [1:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [1:0] bytecnt;
  reg [7:0] cmd_byte;
  reg [7:0] hi_byte;
  reg [1:0] rptr;
  reg rd_lo;
  reg nacked;
  reg [15:0] rd_word;
  reg [3:0] in_we, dac_we_data, dac_we_copy;
  reg [15:0] wdata;
  wire [15:0] bank_rdata;
  wire [63:0] bank_dac;
  reg ld_dummy_a0, ld_dummy_a1, a0_s1, a1_s1;
  // Strap levels pass through two synchroniser flops before the address compare
  wire [6:0] my_addr = {`QDAC_ADDR_HI, ld_dummy_a1, ld_dummy_a0};
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a0_s1 <= 1'b0;
      a1_s1 <= 1'b0;
      ld_dummy_a0 <= 1'b0;
      ld_dummy_a1 <= 1'b0;
    end else begin
      a0_s1 <= addr_strap_bit0;
      a1_s1 <= addr_strap_bit1;
      ld_dummy_a0 <= a0_s1;
      ld_dummy_a1 <= a1_s1;
    end
  end
  wire [7:0] shifted = {shreg[6:0], sda_s2};
  wire [3:0] mask = cmd_byte[3:0];
  wire [3:0] code = cmd_byte[7:4];
  reg ld_dummy_ld;
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      ld_dummy_ld <= 1'b1;
    else
      ld_dummy_ld <= ld_s2;
  end
  wire ld_fall = ~ld_s2 & ld_dummy_ld;
  reg [15:0] wdata_now;
  always @* begin
    wdata_now = wdata;
  end
  // Lowest selected channel, A when several are selected
  reg [1:0] first_ch;
  always @* begin
    first_ch = `QDAC_CH_A;
    if (shifted[3:0] == 4'h2)
      first_ch = 2'h1;
    else if (shifted[3:0] == 4'h4)
      first_ch = 2'h2;
    else if (shifted[3:0] == 4'h8)
      first_ch = `QDAC_CH_D;
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      bytecnt <= 2'h0;
      cmd_byte <= 8'h00;
      hi_byte <= 8'h00;
      rptr <= `QDAC_CH_A;
      rd_lo <= 1'b0;
      nacked <= 1'b0;
      rd_word <= 16'h0000;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      in_we <= 4'h0;
      dac_we_data <= 4'h0;
      dac_we_copy <= 4'h0;
      wdata <= 16'h0000;
      pwrdn_mode <= {`QDAC_MODE_NORMAL, `QDAC_MODE_NORMAL,
                     `QDAC_MODE_NORMAL, `QDAC_MODE_NORMAL};
    end else begin
      in_we <= 4'h0;
      dac_we_data <= 4'h0;
      dac_we_copy <= 4'h0;
      // Falling strobe edge moves every input register to its DAC
      if (ld_fall)
        dac_we_copy <= 4'hF;
      if (start_det) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        bytecnt <= 2'h0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR, ST_WRITE: begin
            if (scl_rise && bitcnt <= `QDAC_BIT_LAST) begin
              shreg <= shifted;
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == `QDAC_BIT_ACK) begin
              // Ninth pulse: pull SDA low unless the address missed
              if (state == ST_ADDR) begin
                if (shreg[7:1] == my_addr) begin
                  sda_oe <= 1'b1;
                  sda_out <= 1'b0;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                sda_oe <= 1'b1;
                sda_out <= 1'b0;
                bytecnt <= bytecnt + 2'h1;
                if (bytecnt == 2'h0) begin
                  cmd_byte <= shreg;
                  if (shreg[7:4] == `QDAC_CMD_NOP)
                    rptr <= first_ch_r(shreg[3:0]);
                end else if (bytecnt == 2'h1) begin
                  hi_byte <= shreg;
                end else if (bytecnt == 2'h2) begin
                  wdata <= {hi_byte, shreg};
                  // Write and update codes apply to every channel in the mask at once
                  case (code)
                    `QDAC_CMD_WR_IN: begin
                      in_we <= mask;
                      if (!ld_s2)
                        dac_we_data <= mask;
                    end
                    // Keep a strobe copy landing in the same cycle
                    `QDAC_CMD_UPD:
                      dac_we_copy <= mask | {4{ld_fall}};
                    `QDAC_CMD_WR_UPD: begin
                      in_we <= mask;
                      dac_we_data <= mask;
                    end
                    `QDAC_CMD_PWRDN: pwrdn_mode <= shreg;
                    default: ;
                  endcase
                end
              end
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt > `QDAC_BIT_ACK) begin
              // Release after ack; choose direction from the address bit
              sda_oe <= 1'b0;
              bitcnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shreg[0]) begin
                  state <= ST_READ;
                  rd_lo <= 1'b0;
                  nacked <= 1'b0;
                  rd_word <= bank_rdata;
                  sda_oe <= ~bank_rdata[15];
                  sda_out <= 1'b0;
                  bitcnt <= 4'h1;
                  shreg <= {bank_rdata[14:8], 1'b0};
                end else begin
                  state <= ST_WRITE;
                end
              end
            end
          end
          ST_READ: begin
            if (scl_fall && !nacked) begin
              if (bitcnt <= `QDAC_BIT_LAST) begin
                // Open-drain: drive only zeros, release for ones
                sda_oe <= ~shreg[7];
                sda_out <= 1'b0;
                shreg <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end else if (bitcnt == `QDAC_BIT_ACK) begin
                sda_oe <= 1'b0;
                bitcnt <= bitcnt + 4'h1;
              end else begin
                bitcnt <= 4'h1;
                if (!rd_lo) begin
                  rd_lo <= 1'b1;
                  sda_oe <= ~rd_word[7];
                  sda_out <= 1'b0;
                  shreg <= {rd_word[6:0], 1'b0};
                end else begin
                  rd_lo <= 1'b0;
                  rd_word <= bank_rdata;
                  sda_oe <= ~bank_rdata[15];
                  sda_out <= 1'b0;
                  shreg <= {bank_rdata[14:8], 1'b0};
                end
              end
            end else if (scl_rise && bitcnt == `QDAC_BIT_NAK) begin
              if (sda_s2)
                nacked <= 1'b1;
              else if (rd_lo)
                rptr <= rptr + 2'h1;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
  function [1:0] first_ch_r;
    input [3:0] m;
    begin
      first_ch_r = `QDAC_CH_A;
      if (m == 4'h2)
        first_ch_r = 2'h1;
      else if (m == 4'h4)
        first_ch_r = 2'h2;
      else if (m == 4'h8)
        first_ch_r = `QDAC_CH_D;
    end
  endfunction
  qdac_regbank u_bank (
    .clk(clk),
    .resetn(resetn),
    .in_we(in_we),
    .dac_we_data(dac_we_data),
    .dac_we_copy(dac_we_copy),
    .wdata(wdata_now),
    .rsel(rptr),
    .rdata(bank_rdata),
    .dac_flat(bank_dac)
  );
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      dac_value <= {4{`QDAC_DATA_RESET}};
    else
      dac_value <= bank_dac;
  end
endmodule

// ===== rtl/qdac_defines.vh
// Constants of the quad converter two-wire command port
`ifndef QDAC_DEFINES_VH
`define QDAC_DEFINES_VH
`define QDAC_ADDR_HI 5'h03
`define QDAC_CMD_NOP 4'h0
`define QDAC_CMD_WR_IN 4'h1
`define QDAC_CMD_UPD 4'h2
`define QDAC_CMD_WR_UPD 4'h3
`define QDAC_CMD_PWRDN 4'h4
`define QDAC_MODE_NORMAL 2'h0
`define QDAC_MODE_1K 2'h1
`define QDAC_MODE_100K 2'h2
`define QDAC_MODE_TRI 2'h3
`define QDAC_BIT_LAST 4'h7
`define QDAC_BIT_ACK 4'h8
`define QDAC_BIT_NAK 4'h9
`define QDAC_BYTE_CMD 2'h1
`define QDAC_BYTE_HI 2'h2
`define QDAC_BYTE_LO 2'h3
`define QDAC_DATA_RESET 16'h0000
`define QDAC_CH_A 2'h0
`define QDAC_CH_D 2'h3
`endif

// ===== rtl/qdac_regbank.v
// Per-channel input and DAC register bank with registered read port
`timescale 1ns/1ps
`include "qdac_defines.vh"
module qdac_regbank (
  input wire clk,
  input wire resetn,
  input wire [3:0] in_we,
  input wire [3:0] dac_we_data,
  input wire [3:0] dac_we_copy,
  input wire [15:0] wdata,
  input wire [1:0] rsel,
  output reg [15:0] rdata,
  output wire [63:0] dac_flat
);
  reg [15:0] in_reg [0:3];
  reg [15:0] dac_reg [0:3];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : ch
      assign dac_flat[g*16 +: 16] = dac_reg[g];
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          in_reg[g] <= `QDAC_DATA_RESET;
          dac_reg[g] <= `QDAC_DATA_RESET;
        end else begin
          if (in_we[g])
            in_reg[g] <= wdata;
          // Direct data wins over copy when both are asked in one cycle
          if (dac_we_data[g])
            dac_reg[g] <= wdata;
          else if (dac_we_copy[g])
            dac_reg[g] <= in_reg[g];
        end
      end
    end
  endgenerate
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      rdata <= `QDAC_DATA_RESET;
    else
      rdata <= in_reg[rsel];
  end
endmodule

// ===== tb/qdac_master.sv
// Bus master model that drives the command port from the bench
`timescale 1ns/1ps
module qdac_master (
  input wire clk,
  input wire sda,
  output logic scl,
  output logic sda_lo
);
  initial begin
    scl = 1'h1;
    sda_lo = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // --------
  // Bus conditions
  // --------
  task automatic start();
    sda_lo <= 1'h0;
    tick(2);
    scl <= 1'h1;
    tick(2);
    sda_lo <= 1'h1;
    tick(2);
    scl <= 1'h0;
    tick(2);
  endtask
  // Data only moves mid-low so it is settled across the high phase
  task automatic clk_bit(input logic lo, output logic r);
    sda_lo <= lo;
    tick(2);
    scl <= 1'h1;
    tick(4);
    r = sda;
    scl <= 1'h0;
    tick(2);
  endtask
  task automatic xfer(input [7:0] d, input logic ack_lo, output [7:0] q,
                      output logic nak);
    for (int i = 7; i >= 0; i--) clk_bit(!d[i], q[i]);
    clk_bit(ack_lo, nak);
  endtask
  task automatic stop();
    sda_lo <= 1'h1;
    tick(2);
    scl <= 1'h1;
    tick(2);
    sda_lo <= 1'h0;
    tick(4);
  endtask
endmodule

// ===== tb/qdac_chk.sv
// Assertion checker for the two-wire command port
`timescale 1ns/1ps
module qdac_chk (
  input wire clk,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire load_strobe_n,
  input wire [63:0] dac_value,
  input wire [7:0] pwrdn_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_od;
    sda_oe |-> !sda_out;
  endproperty
  a_od: assert property (p_od)
    else $error("driven sda not low");
  property p_chg;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in);
  endproperty
  a_chg: assert property (p_chg)
    else $error("sda moved while scl high");
  property p_hold;
    $rose(sda_oe) |=> sda_oe [*4];
  endproperty
  a_hold: assert property (p_hold)
    else $error("low drive too short");
  property p_start;
    scl_in && $past(scl_in) && $fell(sda_in) |=> !sda_oe [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("sda driven during address");
  property p_dac;
    $changed(dac_value) |-> sda_oe || !load_strobe_n;
  endproperty
  a_dac: assert property (p_dac)
    else $error("dac moved outside frame end or strobe");
  property p_pwr;
    $changed(pwrdn_mode) |-> !scl_in;
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("mode moved while scl high");
  property p_keep;
    $changed(pwrdn_mode) |-> $stable(dac_value);
  endproperty
  a_keep: assert property (p_keep)
    else $error("power change altered dac");
  property p_rst;
    $rose(resetn) |-> !sda_oe && pwrdn_mode == 8'h00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("not idle after reset");
endmodule
bind qdac_i2c_port qdac_chk u_chk (.clk(clk), .resetn(resetn),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .load_strobe_n(load_strobe_n), .dac_value(dac_value),
  .pwrdn_mode(pwrdn_mode));

// ===== tb/test_quad_dac_i2c_command_port.sv
// Self-checking bench for the two-wire command port
`timescale 1ns/1ps
module test_quad_dac_i2c_command_port;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic addr_strap_bit0 = 1'h0;
  logic addr_strap_bit1 = 1'h0;
  logic load_strobe_n = 1'h1;
  logic ok;
  wire scl;
  wire m_lo;
  wire sda_out;
  wire sda_oe;
  wire [63:0] dac_value;
  wire [7:0] pwrdn_mode;
  // Pull-up: a released line reads high
  wire sda = !(m_lo || (sda_oe && !sda_out));
  int err_count = 0;
  int compares = 0;
  logic [15:0] inreg [4] = '{16'h0F0F, 16'h7777, 16'h5555, 16'h5555};
  logic [23:0] fr [7] = '{24'h311234, 24'h3AABCD, 24'h1F5555, 24'h4000E4,
                          24'h240000, 24'hFFFFFF, 24'h400000};
  logic [63:0] ed [7] = '{64'h1234, {48'hABCD0000ABCD, 16'h1234},
    {48'hABCD0000ABCD, 16'h1234}, {48'hABCD0000ABCD, 16'h1234},
    {48'hABCD5555ABCD, 16'h1234}, {48'hABCD5555ABCD, 16'h1234},
    {48'hABCD5555ABCD, 16'h1234}};
  logic [7:0] ep [7] = '{8'h00, 8'h00, 8'h00, 8'hE4, 8'hE4, 8'hE4, 8'h00};
  qdac_i2c_port dut (.clk(clk), .resetn(resetn), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_bit0(addr_strap_bit0), .addr_strap_bit1(addr_strap_bit1),
    .load_strobe_n(load_strobe_n), .dac_value(dac_value),
    .pwrdn_mode(pwrdn_mode));
  qdac_master m (.clk(clk), .sda(sda), .scl(scl), .sda_lo(m_lo));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // --------
  // Frame tasks
  // --------
  task automatic send(input [6:0] a, input [23:0] f, input logic stp,
                      output logic good);
    logic [7:0] q;
    logic [3:0] n;
    m.start();
    m.xfer({a, 1'h0}, 1'h0, q, n[0]);
    for (int i = 0; i < 3; i++) m.xfer(f[23-8*i -: 8], 1'h0, q, n[i+1]);
    if (stp) m.stop();
    if (stp) m.tick(6);
    good = !(|n);
  endtask
  task automatic rdback(input [3:0] mask, input int p0, input int cnt);
    logic [7:0] hi;
    logic [7:0] lo;
    logic k;
    send(7'h0C, {4'h0, mask, 16'h0000}, 1'h0, k);
    m.start();
    m.xfer({7'h0C, 1'h1}, 1'h0, hi, k);
    chk("read ack", 64'h0, {63'h0, k});
    for (int i = 0; i < cnt; i++) begin
      m.xfer(8'hFF, 1'h1, hi, k);
      m.xfer(8'hFF, i < cnt - 1, lo, k);
      chk("readback", {48'h0, inreg[(p0+i)%4]}, {48'h0, hi, lo});
    end
    m.stop();
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    m.tick(3);
    for (int i = 0; i < 7; i++) begin
      send(7'h0C, fr[i], 1'h1, ok);
      chk("ack", 64'h1, {63'h0, ok});
      chk("dac", ed[i], dac_value);
      chk("mode", {56'h0, ep[i]}, {56'h0, pwrdn_mode});
    end
    // Strobe falling copies every input first, then the write lands on A
    load_strobe_n <= 1'h0;
    send(7'h0C, 24'h110F0F, 1'h1, ok);
    chk("dac", 64'h5555555555550F0F, dac_value);
    load_strobe_n <= 1'h1;
    send(7'h0C, 24'h127777, 1'h1, ok);
    chk("dac", 64'h5555555555550F0F, dac_value);
    load_strobe_n <= 1'h0;
    m.tick(8);
    load_strobe_n <= 1'h1;
    chk("dac", 64'h5555555577770F0F, dac_value);
    rdback(4'h8, 3, 2);
    rdback(4'h6, 0, 4);
    send(7'h0D, 24'h31FFFF, 1'h1, ok);
    chk("ack", 64'h0, {63'h0, ok});
    chk("dac", 64'h5555555577770F0F, dac_value);
    addr_strap_bit0 <= 1'h1;
    send(7'h0D, 24'h312468, 1'h1, ok);
    chk("dac", 64'h5555555577772468, dac_value);
    addr_strap_bit1 <= 1'h1;
    send(7'h0F, 24'h381357, 1'h1, ok);
    chk("dac", 64'h1357555577772468, dac_value);
    resetn <= 1'h0;
    m.tick(2);
    chk("reset", 64'h0, dac_value | {55'h0, pwrdn_mode, sda_oe});
    complete_run();
  end
endmodule
